// *** hdl/aou_unit.sv ***
// accumulator OR / XOR logic-operation unit with zero and negative flags
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1 - word OR: low accumulator half with memory
// RULE2 - word OR sets zero flag on zero
// RULE3 - word OR operand fetched at direct address
// RULE4 - double OR: accumulator with 32-bit constant
// RULE5 - double OR updates zero and negative flags
// RULE6 - flags hold until next flag-updating operation
// RULE7 - formatted OR merges 1 to 32 bits
// RULE8 - formatted OR takes start address, bit count
// RULE9 - formatted OR updates zero and negative flags
// RULE10 - word XOR: low accumulator half with memory
// RULE11 - word XOR sets zero flag on zero
// RULE12 - start bit maps to accumulator bit zero
module aou_unit (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic req_valid,
   input wire aou_pkg::aou_cmd_t req_cmd,
   input wire logic acc_wr_en,
   input wire logic [aou_pkg::ACC_W-1:0] acc_wr_data,
   output var logic mem_rd_q,
   output var logic [aou_pkg::ADDR_W-1:0] mem_addr_q,
   input wire logic [aou_pkg::WORD_W-1:0] mem_rd_data,
   output var logic bit_rd_q,
   output var logic [aou_pkg::ADDR_W-1:0] bit_addr_q,
   input wire logic [aou_pkg::ACC_W-1:0] bit_rd_data,
   output var logic busy_q,
   output var logic done_q,
   output var logic [aou_pkg::ACC_W-1:0] acc_q,
   output var logic zero_result_flag,
   output var logic negative_result_flag
);
   import aou_pkg::*;

   typedef enum logic [1:0] {st_idle, st_fetch, st_use} aou_state_t;

   aou_state_t state_q;
   aou_state_t state_d;
   aou_op_t op_q;
   logic [CNT_W-1:0] cnt_q;
   logic [ACC_W-1:0] acc_d;
   logic take;
   logic fin;
   logic upd_neg;
   logic acc_we;

   // ==========================================================
   // helpers
   function automatic logic is_zero(input logic [ACC_W-1:0] v);
      return v == ACC_RST;
   endfunction

   // ones in the low cnt positions, count clamped to 1..32
   function automatic logic [ACC_W-1:0] fmt_mask(input logic [CNT_W-1:0] c);
      logic [CNT_W-1:0] n;
      logic [ACC_W-1:0] m;
      n = (c < CNT_MIN) ? CNT_MIN : ((c > CNT_MAX) ? CNT_MAX : c);
      m = '0;
      for (int i = 0; i < ACC_W; i++) begin
         m[i] = (i < int'(n));
      end
      return m;
   endfunction

   assign take = req_valid && (state_q == st_idle);

   // ==========================================================
   // sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         st_idle: begin
            if (take && req_cmd.op != or_double_op) begin
               state_d = st_fetch;
            end
         end
         st_fetch: state_d = st_use;
         st_use: state_d = st_idle;
         default: state_d = st_idle;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= st_idle;
         busy_q <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         busy_q <= (state_d != st_idle);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         op_q <= op_word_or;
         cnt_q <= CNT_MIN;
      end else if (ce && take) begin
         op_q <= req_cmd.op;
         cnt_q <= req_cmd.cnt; // [RULE8]
      end
   end

   // ==========================================================
   // operand fetch
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mem_rd_q <= 1'b0;
         mem_addr_q <= '0;
         bit_rd_q <= 1'b0;
         bit_addr_q <= '0;
      end else if (ce) begin
         mem_rd_q <= take && (req_cmd.op == op_word_or || req_cmd.op == op_word_xor); // [RULE3]
         bit_rd_q <= take && (req_cmd.op == or_formatted_op); // [RULE8]
         if (take) begin
            mem_addr_q <= req_cmd.addr; // [RULE3]
            bit_addr_q <= req_cmd.addr; // [RULE8]
         end
      end
   end

   // ==========================================================
   // datapath
   always_comb begin
      acc_d = acc_q;
      fin = 1'b0;
      upd_neg = 1'b0;
      acc_we = 1'b0;
      if (take && req_cmd.op == or_double_op) begin
         acc_d = acc_q | req_cmd.konst; // [RULE4]
         fin = 1'b1;
         upd_neg = 1'b1;
      end else if (state_q == st_use) begin
         fin = 1'b1;
         case (op_q)
            op_word_or: acc_d = {acc_q[ACC_W-1:WORD_W], acc_q[WORD_W-1:0] | mem_rd_data}; // [RULE1]
            op_word_xor: acc_d = {acc_q[ACC_W-1:WORD_W], acc_q[WORD_W-1:0] ^ mem_rd_data}; // [RULE10]
            or_formatted_op: begin
               acc_d = acc_q | (bit_rd_data & fmt_mask(cnt_q)); // [RULE7] [RULE12]
               upd_neg = 1'b1;
            end
            default: acc_d = acc_q;
         endcase
      end else if (state_q == st_idle && !take && acc_wr_en) begin
         acc_d = acc_wr_data;
      end
      acc_we = fin || (state_q == st_idle && !take && acc_wr_en);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_q <= ACC_RST;
      end else if (ce && acc_we) begin
         acc_q <= acc_d;
      end
   end

   // flags change only when an operation completes; negative only on double or formatted OR
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         zero_result_flag <= FLAG_RST;
         negative_result_flag <= FLAG_RST;
         done_q <= 1'b0;
      end else if (ce) begin
         done_q <= fin;
         if (fin) begin
            zero_result_flag <= is_zero(acc_d); // [RULE2] [RULE5] [RULE9] [RULE11] [RULE6]
            if (upd_neg) begin
               negative_result_flag <= acc_d[ACC_W-1]; // [RULE5] [RULE9] [RULE6]
            end
         end
      end
   end

   // ==========================================================
   // checks
   sequence s_word_start;
      take && (req_cmd.op == op_word_or || req_cmd.op == op_word_xor);
   endsequence

   sequence s_word_fetch;
      mem_rd_q && state_q == st_fetch;
   endsequence

   chk_word_fetch_addr: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE3]
      s_word_start |=> s_word_fetch ##0 (mem_addr_q == $past(req_cmd.addr)))
      else $error("word fetch address or strobe wrong");

   chk_word_or_result: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE1]
      (state_q == st_use && op_q == op_word_or) |=>
      acc_q == {$past(acc_q[ACC_W-1:WORD_W]), $past(acc_q[WORD_W-1:0]) | $past(mem_rd_data)})
      else $error("word OR result wrong");

   chk_word_xor_result: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE10]
      (state_q == st_use && op_q == op_word_xor) |=>
      acc_q == {$past(acc_q[ACC_W-1:WORD_W]), $past(acc_q[WORD_W-1:0]) ^ $past(mem_rd_data)})
      else $error("word XOR result wrong");

   chk_word_zero_flag: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE2] [RULE11]
      s_word_start |-> ##3 done_q && (zero_result_flag == (acc_q == ACC_RST)) && $stable(negative_result_flag))
      else $error("word op zero flag wrong");

   chk_double_result: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE4]
      (take && req_cmd.op == or_double_op) |=> done_q && acc_q == ($past(acc_q) | $past(req_cmd.konst)))
      else $error("double OR result wrong");

   chk_double_flags: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE5]
      (take && req_cmd.op == or_double_op) |=>
      zero_result_flag == (acc_q == ACC_RST) && negative_result_flag == acc_q[ACC_W-1])
      else $error("double OR flags wrong");

   chk_fmt_result: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE7] [RULE12]
      (state_q == st_use && op_q == or_formatted_op) |=>
      acc_q == ($past(acc_q) | ($past(bit_rd_data) & fmt_mask($past(cnt_q)))))
      else $error("formatted OR result wrong");

   chk_fmt_flags: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE9] [RULE8]
      (take && req_cmd.op == or_formatted_op) |=> bit_rd_q ##2
      done_q && zero_result_flag == (acc_q == ACC_RST) && negative_result_flag == acc_q[ACC_W-1])
      else $error("formatted OR fetch or flags wrong");

   chk_flags_hold: assert property (@(posedge clk_sys) disable iff (rst || !ce) // [RULE6]
      !$past(fin) |-> $stable(zero_result_flag) && $stable(negative_result_flag))
      else $error("flags changed without an operation");

endmodule // aou_unit

`default_nettype wire

// *** hdl/aou_pkg.sv ***
// shared types and constants for the accumulator logic-operation unit
package aou_pkg;
   localparam int ACC_W = 32;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 16;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] CNT_MIN = 6'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 6'h20;
   localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
   localparam logic FLAG_RST = 1'b0;

   typedef enum logic [1:0] {
      op_word_or,
      or_double_op,
      or_formatted_op,
      op_word_xor
   } aou_op_t;

   typedef struct packed {
      aou_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [ACC_W-1:0] konst;
      logic [CNT_W-1:0] cnt;
   } aou_cmd_t;
endpackage

// *** sim/testbench.sv ***
// self-checking bench for the accumulator logic-operation unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import aou_pkg::*;
   typedef struct {aou_op_t op; logic [15:0] a; logic [31:0] k; logic [5:0] c; logic [15:0] m;
      logic [31:0] b; logic [31:0] s; logic [31:0] e; logic z; logic n;} aou_row_t;
   // ==========
   // rows: op, addr, const, count, word, bits, seed, result, zero, negative
   aou_row_t rows[12] = '{
      '{or_double_op, 16'h0, 32'h0, 6'h0, 16'h0, 32'h0, 32'h0, 32'h0, 1'b1, 1'b0},
      '{or_double_op, 16'h0, 32'h8000_000f, 6'h0, 16'h0, 32'h0, 32'hf0, 32'h8000_00ff, 1'b0, 1'b1},
      '{op_word_or, 16'h10, 32'h0, 6'h0, 16'h0f00, 32'h0, 32'h1_00f0, 32'h1_0ff0, 1'b0, 1'b1},
      '{op_word_or, 16'hffff, 32'h0, 6'h0, 16'h0, 32'h0, 32'h0, 32'h0, 1'b1, 1'b1},
      '{op_word_xor, 16'h1, 32'h0, 6'h0, 16'ha5a5, 32'h0, 32'ha5a5, 32'h0, 1'b1, 1'b1},
      '{op_word_xor, 16'h1234, 32'h0, 6'h0, 16'hff00, 32'h0, 32'h1234_00ff, 32'h1234_ffff, 1'b0, 1'b1},
      '{or_formatted_op, 16'h100, 32'h0, 6'h4, 16'h0, 32'hffff_fffa, 32'h0, 32'ha, 1'b0, 1'b0},
      '{or_formatted_op, 16'h0, 32'h0, 6'h20, 16'h0, 32'h8000_0001, 32'h0, 32'h8000_0001, 1'b0, 1'b1},
      '{or_formatted_op, 16'h200, 32'h0, 6'h0, 16'h0, 32'h2, 32'h0, 32'h0, 1'b1, 1'b0},
      '{or_formatted_op, 16'h300, 32'h0, 6'h3f, 16'h0, 32'hf000_0000, 32'h0, 32'hf000_0000, 1'b0, 1'b1},
      '{or_formatted_op, 16'h7, 32'h0, 6'h1, 16'h0, 32'hffff_ffff, 32'h10, 32'h11, 1'b0, 1'b0},
      '{or_double_op, 16'h0, 32'h0, 6'h0, 16'h0, 32'h0, 32'h7fff_ffff, 32'h7fff_ffff, 1'b0, 1'b0}};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic req_valid = 1'b0;
   aou_cmd_t req_cmd = '0;
   logic acc_wr_en = 1'b0;
   logic [31:0] acc_wr_data = 32'h0;
   logic [15:0] mem_rd_data = 16'h0;
   logic [31:0] bit_rd_data = 32'h0;
   logic mem_rd_q, bit_rd_q, busy_q, done_q, zero_result_flag, negative_result_flag;
   logic [15:0] mem_addr_q, bit_addr_q;
   logic [31:0] acc_q;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;

   aou_unit u_aou_unit (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req_valid(req_valid), .req_cmd(req_cmd),
      .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
      .mem_rd_data(mem_rd_data), .bit_rd_q(bit_rd_q), .bit_addr_q(bit_addr_q), .bit_rd_data(bit_rd_data),
      .busy_q(busy_q), .done_q(done_q), .acc_q(acc_q), .zero_result_flag(zero_result_flag),
      .negative_result_flag(negative_result_flag));

   always #25 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic load(input logic [31:0] v);
      @(posedge clk_sys);
      acc_wr_en <= 1'b1;
      acc_wr_data <= v;
      @(posedge clk_sys);
      acc_wr_en <= 1'b0;
   endtask

   task automatic run(input aou_row_t r);
      int lat;
      @(posedge clk_sys);
      mem_rd_data <= r.m;
      bit_rd_data <= r.b;
      req_valid <= 1'b1;
      req_cmd <= '{op: r.op, addr: r.a, konst: r.k, cnt: r.c};
      @(posedge clk_sys);
      req_valid <= 1'b0;
      lat = 1;
      #1;
      chk("busy", 32'(busy_q), (r.op == or_double_op) ? 32'h0 : 32'h1);
      if (r.op == op_word_or || r.op == op_word_xor) begin
         chk("mem_rd", 32'(mem_rd_q), 32'h1);
         chk("mem_addr", 32'(mem_addr_q), 32'(r.a));
      end
      if (r.op == or_formatted_op) begin
         chk("bit_rd", 32'(bit_rd_q), 32'h1);
         chk("bit_addr", 32'(bit_addr_q), 32'(r.a));
      end
      while (done_q !== 1'b1 && lat < 8) begin
         @(posedge clk_sys);
         #1;
         lat++;
      end
      chk("latency", 32'(lat), (r.op == or_double_op) ? 32'h1 : 32'h3);
      chk("acc", acc_q, r.e);
      chk("zero", 32'(zero_result_flag), 32'(r.z));
      chk("neg", 32'(negative_result_flag), 32'(r.n));
      chk("idle", 32'(busy_q), 32'h0);
   endtask

   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk("rst acc", acc_q, 32'h0);
      chk("rst flags", {30'h0, zero_result_flag, negative_result_flag}, 32'h0);
      chk("rst busy", {30'h0, busy_q, done_q}, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         load(rows[i].s);
         run(rows[i]);
      end
      $display("test table done");
      // ==========
      // two constant ORs on consecutive edges
      load(32'h0);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_cmd <= '{op: or_double_op, addr: 16'h0, konst: 32'h1, cnt: 6'h0};
      @(posedge clk_sys);
      req_cmd.konst <= 32'h8000_0000;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      #1;
      chk("b2b acc", acc_q, 32'h8000_0001);
      chk("b2b neg", 32'(negative_result_flag), 32'h1);
      $display("test back to back done");
      // ==========
      // request presented while busy is ignored
      load(32'h0f0f);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_cmd <= '{op: op_word_xor, addr: 16'h40, konst: 32'hffff_ffff, cnt: 6'h0};
      mem_rd_data <= 16'h0f0f;
      @(posedge clk_sys);
      req_cmd.op <= or_double_op;
      acc_wr_en <= 1'b1;
      acc_wr_data <= 32'hffff_ffff;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      acc_wr_en <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("busy done", 32'(done_q), 32'h1);
      chk("busy acc", acc_q, 32'h0);
      chk("busy zero", 32'(zero_result_flag), 32'h1);
      @(posedge clk_sys);
      #1;
      chk("done pulse", 32'(done_q), 32'h0);
      $display("test refused request done");
      // ==========
      // clock enable low freezes an operation in flight
      load(32'h0001_0000);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_cmd <= '{op: op_word_or, addr: 16'h55, konst: 32'h0, cnt: 6'h0};
      mem_rd_data <= 16'h8001;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      ce <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("ce strobe", 32'(mem_rd_q), 32'h1);
      chk("ce busy", 32'(busy_q), 32'h1);
      chk("ce acc", acc_q, 32'h0001_0000);
      @(posedge clk_sys);
      ce <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("ce done", 32'(done_q), 32'h1);
      chk("ce acc", acc_q, 32'h0001_8001);
      chk("ce zero", 32'(zero_result_flag), 32'h0);
      $display("test clock enable done");
      // ==========
      // reset in the middle of an operation
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_cmd <= '{op: or_formatted_op, addr: 16'h9, konst: 32'h0, cnt: 6'h8};
      @(posedge clk_sys);
      req_valid <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk("mid rst acc", acc_q, 32'h0);
      chk("mid rst flags", {30'h0, zero_result_flag, negative_result_flag}, 32'h0);
      chk("mid rst strobes", {28'h0, bit_rd_q, mem_rd_q, busy_q, done_q}, 32'h0);
      chk("mid rst addr", 32'(bit_addr_q), 32'h0);
      run(aou_row_t'{or_double_op, 16'h0, 32'h4, 6'h0, 16'h0, 32'h0, 32'h0, 32'h4, 1'b0, 1'b0});
      $display("test mid reset done");
      results();
   end
endmodule // testbench
`default_nettype wire
